// [rtl/dto_odt_ctrl.sv]
// Summary of operation
// - Dynamic termination is on when MR2 bit 9 or bit 10 is set.
// - MR1 bits 9,6,2 select nominal: off, 60, 120, 40, 20, 30; 110/111 reserved.
// - MR2 bits 10,9 select write value: off, 60, 120; 11 reserved.
// - Without reads or writes nominal strength applies, switched by delayed ODT.
// - Every write variant, BC4 or BL8, fixed or on the fly, starts switching.
// - Write strength starts WL minus 2 cycles after write registration.
// - Nominal returns ODTL off plus 6 (BL8) or plus 4 (BC4) cycles after write.
// - Termination value is undefined briefly after the nominal-to-write switch.
// - In dynamic mode on/off still follows ODT pin latencies and high times.
// - Synchronous mode needs DLL on and locked, termination enabled, allowed state.
// - Termination turns on/off ODTL cycles after ODT is sampled high/low.
// - Both ODT latencies equal CWL plus AL minus 2.
// - Internal ODT lags the pin by ODTL, which holds the additive latency from MR1 bits 4,3.
// - With write termination off, writes use the nominal value.
module dto_odt_ctrl
	import dto_pkg::*;
(
	input wire logic pclk, // Clock, 125 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high for write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready, always high
	output logic pslverr, // APB error on unmapped address
	input wire dto_cmd_s cmd_i, // ODT pin and write command pins
	output dto_term_s term_o // Applied termination
);

	// Software-visible mode and state registers
	logic [15:0] mr0_q;
	logic [15:0] mr1_q;
	logic [15:0] mr2_q;
	logic [4:0] ctrl_q;

	// Pin histories, termination enable and the write-strength window
	logic [DTO_HIST_LEN-1:0] odt_hist_q;
	logic [DTO_HIST_LEN-1:0] wr_hist_q;
	logic [DTO_HIST_LEN-1:0] bc4_hist_q;
	logic term_on_q;
	logic wr_win_q;
	logic [3:0] wr_cnt_q;

	// Applied result, current and next
	dto_term_e state_q;
	dto_term_e state_d;
	logic [7:0] ohms_q;
	logic [7:0] ohms_d;
	logic undef_q;

	// Decoded fields, latencies and delayed pin samples
	logic [2:0] nom_code;
	logic [1:0] wr_code;
	logic dyn_en;
	logic nom_en;
	logic rsvd_code;
	logic [5:0] cl;
	logic [5:0] cwl;
	logic [5:0] al;
	logic [5:0] odtl;
	logic [4:0] tap;
	logic sync_mode;
	logic odt_int;
	logic wr_start;
	logic bc4_start;

	// Bus decode and the status word
	logic acc_wr;
	logic addr_ok;
	logic [31:0] stat_word;

	// Mode register field decode
	assign nom_code = {mr1_q[DTO_MR1_NOM_B2], mr1_q[DTO_MR1_NOM_B1], mr1_q[DTO_MR1_NOM_B0]};
	assign wr_code = mr2_q[DTO_MR2_WR_LSB +: 2];
	assign dyn_en = mr2_q[DTO_MR2_WR_LSB] | mr2_q[DTO_MR2_WR_LSB+1];
	// Reserved nominal codes apply no termination rather than a bogus value
	assign nom_en = (nom_code != DTO_NOM_OFF) && !(nom_code[2] & nom_code[1]);
	// Reserved codes are flagged for software; write code 11 applies 60 ohms
	assign rsvd_code = (nom_code[2] & nom_code[1]) | (wr_code == 2'h3);

	// Latency arithmetic: CL and CWL from their fields, AL from MR1
	// CL matters only through AL; values beyond the speed bins are not refused
	assign cl = DTO_CL_BASE + {3'h0, mr0_q[DTO_MR0_CL_LSB +: 3]};
	assign cwl = DTO_CWL_BASE + {3'h0, mr2_q[DTO_MR2_CWL_LSB +: 3]};

	// AL code 11 is reserved and taken as zero so latency stays sane
	always_comb begin
		unique case (mr1_q[DTO_MR1_AL_LSB +: 2])
			2'h1: al = cl - 6'h01;
			2'h2: al = cl - 6'h02;
			default: al = 6'h00;
		endcase
	end

	// One latency serves turn-on, turn-off and the strength switch
	// It already holds AL, so no separate AL delay line is kept
	assign odtl = cwl + al - DTO_ODTL_SUB;
	// History tap for a sample taken odtl edges ago; saturates at the line length
	// Entry zero holds the last edge's sample, so a latency of n reads entry n-1
	// Latencies above the line length are a known limit: they clip to 32 edges
	assign tap = (odtl > 6'(DTO_HIST_LEN)) ? 5'h1F : 5'(odtl - 6'h01);

	// Synchronous mode needs a running, locked DLL in a state that keeps it
	// Precharge power-down keeps the mode only when the DLL stays on in it
	always_comb begin
		sync_mode = ctrl_q[DTO_CTRL_DLL_ON] & ctrl_q[DTO_CTRL_DLL_LOCK] & (nom_en | dyn_en);
		if (!(ctrl_q[DTO_CTRL_CKE] | ctrl_q[DTO_CTRL_ACT_PD] |
				(ctrl_q[DTO_CTRL_PRE_PD] & mr0_q[DTO_MR0_DLL_PD_BIT]))) begin
			sync_mode = 1'b0;
		end
	end

	// Sampled pin histories; entry k holds the sample from k+1 edges ago
	// A plain shift line keeps every sample, so pulses shorter than the latency
	// still come out in order; area is traded for simplicity here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			odt_hist_q <= '0;
			wr_hist_q <= '0;
			bc4_hist_q <= '0;
		end else begin
			odt_hist_q <= {odt_hist_q[DTO_HIST_LEN-2:0], cmd_i.odt};
			wr_hist_q <= {wr_hist_q[DTO_HIST_LEN-2:0], cmd_i.wr};
			bc4_hist_q <= {bc4_hist_q[DTO_HIST_LEN-2:0], cmd_i.bc4};
		end
	end

	// Delayed ODT already folds AL in, as the latency includes it
	// Write and burst taps match the ODT tap, so the three stay aligned
	assign odt_int = odt_hist_q[tap];
	assign wr_start = wr_hist_q[tap] & dyn_en;
	assign bc4_start = bc4_hist_q[tap];

	// Termination on/off; outside synchronous mode the pin acts without latency
	// Asynchronous mode is simplified to one edge; analog delays are not modelled
	// Both terminations off hold it low whatever the pin does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_on_q <= 1'b0;
		end else if (!(nom_en | dyn_en)) begin
			term_on_q <= 1'b0;
		end else if (sync_mode) begin
			term_on_q <= odt_int;
		end else begin
			term_on_q <= cmd_i.odt;
		end
	end

	// Write-strength window: opens at WL-2 and closes 4 or 6 cycles later
	// Burst length comes from the sample that opened the window
	// With dynamic termination off a write never opens it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_win_q <= 1'b0;
			wr_cnt_q <= 4'h0;
		end else if (!dyn_en) begin
			wr_win_q <= 1'b0;
			wr_cnt_q <= 4'h0;
		end else if (wr_start) begin
			// A later write restarts the window, covering back-to-back bursts
			wr_win_q <= 1'b1;
			wr_cnt_q <= bc4_start ? DTO_CWN4_ADD : DTO_CWN8_ADD;
		end else if (wr_cnt_q == 4'h1) begin
			wr_win_q <= 1'b0;
			wr_cnt_q <= 4'h0;
		end else if (wr_cnt_q != 4'h0) begin
			wr_cnt_q <= wr_cnt_q - 4'h1;
		end
	end

	// Applied state and its value in ohms
	// Write strength wins; with nominal off only the write window terminates
	always_comb begin
		state_d = DTO_TERM_OFF;
		ohms_d = DTO_OHM_OFF;
		if (term_on_q && wr_win_q) begin
			state_d = DTO_TERM_WR;
			ohms_d = (wr_code == DTO_WR_RZQ2) ? DTO_OHM_120 : DTO_OHM_60;
		end else if (term_on_q && nom_en) begin
			state_d = DTO_TERM_NOM;
			unique case (nom_code)
				DTO_NOM_RZQ4: ohms_d = DTO_OHM_60;
				DTO_NOM_RZQ2: ohms_d = DTO_OHM_120;
				DTO_NOM_RZQ6: ohms_d = DTO_OHM_40;
				DTO_NOM_RZQ12: ohms_d = DTO_OHM_20;
				DTO_NOM_RZQ8: ohms_d = DTO_OHM_30;
				default: ohms_d = DTO_OHM_OFF;
			endcase
		end
	end

	// Registered termination result
	// Both fields move on one edge, so state and ohms never disagree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= DTO_TERM_OFF;
			ohms_q <= DTO_OHM_OFF;
		end else begin
			state_q <= state_d;
			ohms_q <= ohms_d;
		end
	end

	// Undefined flag covers the cycle after a nominal-to-write switch
	// Entry from off counts too, as the value is still settling then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			undef_q <= 1'b0;
		end else begin
			undef_q <= (state_d == DTO_TERM_WR) && (state_q != DTO_TERM_WR);
		end
	end

	// Result fields; sync_mode is live so mode changes show at once
	assign term_o.state = state_q;
	assign term_o.ohms = ohms_q;
	assign term_o.undef = undef_q;
	assign term_o.sync_mode = sync_mode;

	// APB decode; the slave never stalls
	// No wait state is needed, as read data is loaded in the setup cycle
	assign acc_wr = psel & penable & pwrite;
	// Only the five aligned offsets are mapped; any other address is refused
	assign addr_ok = (paddr == DTO_MR0_OFS) || (paddr == DTO_MR1_OFS) ||
		(paddr == DTO_MR2_OFS) || (paddr == DTO_CTRL_OFS) || (paddr == DTO_STAT_OFS);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;

	// Mode register writes, two byte lanes each
	// Only the two low lanes exist; upper strobes are ignored
	// A write to an unmapped address changes nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mr0_q <= DTO_MR0_RST;
			mr1_q <= DTO_MR1_RST;
			mr2_q <= DTO_MR2_RST;
		end else if (acc_wr) begin
			for (int b = 0; b < 2; b++) begin
				if (pstrb[b] && paddr == DTO_MR0_OFS) begin
					mr0_q[b*8 +: 8] <= pwdata[b*8 +: 8];
				end
				if (pstrb[b] && paddr == DTO_MR1_OFS) begin
					mr1_q[b*8 +: 8] <= pwdata[b*8 +: 8];
				end
				if (pstrb[b] && paddr == DTO_MR2_OFS) begin
					mr2_q[b*8 +: 8] <= pwdata[b*8 +: 8];
				end
			end
		end
	end

	// Device state bits from the command decoder side
	// Lane zero carries all five state bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= DTO_CTRL_RST;
		end else if (acc_wr && paddr == DTO_CTRL_OFS && pstrb[0]) begin
			ctrl_q <= pwdata[4:0];
		end
	end

	// Status word, field by field
	// Software reads the live latency, so a mode write can be checked at once
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[1:0] = state_q; // Applied state
		stat_word[2] = term_on_q; // Termination on; delayed pin level only in sync mode with a termination enabled
		stat_word[3] = wr_win_q; // Write-strength window
		stat_word[4] = dyn_en;
		stat_word[5] = sync_mode;
		stat_word[6] = rsvd_code; // Reserved code programmed
		stat_word[7] = undef_q;
		stat_word[13:8] = odtl;
	end

	// Read data is loaded at the setup edge and stands through the access phase
	// Unmapped reads return zero; the error itself goes out on pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				DTO_MR0_OFS: prdata <= {16'h0000, mr0_q};
				DTO_MR1_OFS: prdata <= {16'h0000, mr1_q};
				DTO_MR2_OFS: prdata <= {16'h0000, mr2_q};
				DTO_CTRL_OFS: prdata <= {27'h0000000, ctrl_q};
				DTO_STAT_OFS: prdata <= stat_word;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// [common/dto_pkg.sv]
package dto_pkg;

	// APB register byte offsets
	localparam logic [7:0] DTO_MR0_OFS = 8'h00;
	localparam logic [7:0] DTO_MR1_OFS = 8'h04;
	localparam logic [7:0] DTO_MR2_OFS = 8'h08;
	localparam logic [7:0] DTO_CTRL_OFS = 8'h0C;
	localparam logic [7:0] DTO_STAT_OFS = 8'h10;

	// Reset values
	localparam logic [15:0] DTO_MR0_RST = 16'h0000;
	localparam logic [15:0] DTO_MR1_RST = 16'h0000;
	localparam logic [15:0] DTO_MR2_RST = 16'h0000;
	localparam logic [4:0] DTO_CTRL_RST = 5'h00;

	// Mode register field positions
	localparam int DTO_MR0_DLL_PD_BIT = 12;
	localparam int DTO_MR0_CL_LSB = 4;
	localparam int DTO_MR1_NOM_B2 = 9;
	localparam int DTO_MR1_NOM_B1 = 6;
	localparam int DTO_MR1_NOM_B0 = 2;
	localparam int DTO_MR1_AL_LSB = 3;
	localparam int DTO_MR2_CWL_LSB = 3;
	localparam int DTO_MR2_WR_LSB = 9;

	// Control register bit positions
	localparam int DTO_CTRL_DLL_ON = 0;
	localparam int DTO_CTRL_DLL_LOCK = 1;
	localparam int DTO_CTRL_CKE = 2;
	localparam int DTO_CTRL_ACT_PD = 3;
	localparam int DTO_CTRL_PRE_PD = 4;

	// Latency decode bases and burst hold times in clock cycles
	localparam logic [5:0] DTO_CL_BASE = 6'h04;
	localparam logic [5:0] DTO_CWL_BASE = 6'h05;
	localparam logic [5:0] DTO_ODTL_SUB = 6'h02;
	localparam logic [3:0] DTO_CWN8_ADD = 4'h6;
	localparam logic [3:0] DTO_CWN4_ADD = 4'h4;
	localparam int DTO_HIST_LEN = 32;

	// Nominal termination codes from MR1[9,6,2]
	localparam logic [2:0] DTO_NOM_OFF = 3'h0;
	localparam logic [2:0] DTO_NOM_RZQ4 = 3'h1;
	localparam logic [2:0] DTO_NOM_RZQ2 = 3'h2;
	localparam logic [2:0] DTO_NOM_RZQ6 = 3'h3;
	localparam logic [2:0] DTO_NOM_RZQ12 = 3'h4;
	localparam logic [2:0] DTO_NOM_RZQ8 = 3'h5;

	// Write termination codes from MR2[10,9]
	localparam logic [1:0] DTO_WR_OFF = 2'h0;
	localparam logic [1:0] DTO_WR_RZQ4 = 2'h1;
	localparam logic [1:0] DTO_WR_RZQ2 = 2'h2;

	// Ohm values, RZQ = 240
	localparam logic [7:0] DTO_OHM_OFF = 8'h00;
	localparam logic [7:0] DTO_OHM_60 = 8'h3C;
	localparam logic [7:0] DTO_OHM_120 = 8'h78;
	localparam logic [7:0] DTO_OHM_40 = 8'h28;
	localparam logic [7:0] DTO_OHM_20 = 8'h14;
	localparam logic [7:0] DTO_OHM_30 = 8'h1E;

	// Applied termination state, Gray along off -> nominal -> write
	typedef enum logic [1:0] {
		DTO_TERM_OFF = 2'b00,
		DTO_TERM_NOM = 2'b01,
		DTO_TERM_WR = 2'b11
	} dto_term_e;

	// Command pins sampled on each rising edge
	typedef struct packed {
		logic odt;
		logic wr;
		logic bc4;
	} dto_cmd_s;

	// Termination result presented at the outputs
	typedef struct packed {
		dto_term_e state;
		logic [7:0] ohms;
		logic undef;
		logic sync_mode;
	} dto_term_s;

endpackage

// [verification/dto_odt_ctrl_assertions.sv]
module dto_odt_ctrl_assertions
	import dto_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire dto_cmd_s cmd_i, // Pin samples
	input wire dto_term_s term_o // Applied termination
);
	timeunit 1ns;
	timeprecision 1ps;
	// Longest latency is 32 plus register lag, so these spans leave margin
	localparam logic [5:0] ODT_SPAN = 6'h24;
	localparam logic [5:0] WR_SPAN = 6'h2A;
	logic [5:0] odt_age_q;
	logic [5:0] wr_age_q;
	// Cycles since ODT was last sampled high; saturates so it never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) odt_age_q <= 6'h3F;
		else if (cmd_i.odt) odt_age_q <= 6'h00;
		else if (odt_age_q != 6'h3F) odt_age_q <= odt_age_q + 6'h01;
	end
	// Cycles since the last registered write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) wr_age_q <= 6'h3F;
		else if (cmd_i.wr) wr_age_q <= 6'h00;
		else if (wr_age_q != 6'h3F) wr_age_q <= wr_age_q + 6'h01;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY: assert property (pready == 1'b1)
		else $error("ready low");
	AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	AST_UNMAPPED: assert property (psel && penable && paddr > 8'h10 |->
		pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
	AST_STATE_CODE: assert property (term_o.state != 2'b10)
		else $error("illegal state code");
	AST_OFF_OHMS: assert property (term_o.state == DTO_TERM_OFF |-> term_o.ohms == 8'h00)
		else $error("ohms while off");
	AST_NOM_OHMS: assert property (term_o.state == DTO_TERM_NOM |->
		term_o.ohms inside {8'h3C, 8'h78, 8'h28, 8'h14, 8'h1E}) else $error("bad nominal ohms");
	AST_WR_OHMS: assert property (term_o.state == DTO_TERM_WR |->
		term_o.ohms inside {8'h3C, 8'h78}) else $error("bad write ohms");
	AST_UNDEF: assert property (term_o.undef |-> term_o.state == DTO_TERM_WR ##1 !term_o.undef)
		else $error("bad undefined pulse");
	AST_ODT_OFF: assert property (odt_age_q > ODT_SPAN |-> term_o.state == DTO_TERM_OFF)
		else $error("termination without ODT");
	AST_WR_CAUSE: assert property (term_o.state == DTO_TERM_WR |-> wr_age_q < WR_SPAN)
		else $error("write strength without write");
	cover property (term_o.state == DTO_TERM_WR);
	cover property (term_o.undef);
	cover property (pslverr);
	cover property (term_o.sync_mode && term_o.state == DTO_TERM_NOM);
endmodule
bind dto_odt_ctrl dto_odt_ctrl_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr),
	.cmd_i(cmd_i), .term_o(term_o));

// [verification/dto_ctrl_model.sv]
module dto_ctrl_model
	import dto_pkg::*;
(
	input wire logic pclk, // Clock
	output dto_cmd_s cmd // Pins toward the device
);
	timeunit 1ns;
	timeprecision 1ps;
	// No reads are issued, so ODT rests low between pulses
	initial cmd = '{odt: 1'b0, wr: 1'b0, bc4: 1'b1};
	// One ODT pulse, optionally with a write on its first sample
	task automatic pulse(input int hold, input logic w, input logic b4);
		int h;
		h = (hold < 4) ? 4 : hold;
		if (w && !b4 && h < 6) h = 6;
		@(posedge pclk);
		cmd <= '{odt: 1'b1, wr: w, bc4: b4};
		repeat (h) begin
			@(posedge pclk);
			cmd.wr <= 1'b0;
			cmd.bc4 <= ~cmd.bc4; // Burst line carries no meaning outside a write
		end
		cmd.odt <= 1'b0;
	endtask
endmodule

// [verification/testbench.sv]
module testbench
	import dto_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dto_cmd_s cmd;
	dto_term_s term;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int seed = 25230;
	int odtl;
	logic [31:0] r;
	logic [31:0] q;
	logic e;
	logic [2:0] nc;
	logic [1:0] wc;
	logic b4;
	logic [10:0] nv;
	logic [10:0] mv;
	// Expected sync mode, precharge DLL bit, control bits
	logic [7:0] stab[6] = '{8'h87, 8'h8B, 8'hB3, 8'h13, 8'h06, 8'h05};
	dto_odt_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_i(cmd), .term_o(term));
	dto_ctrl_model u_model (.pclk(pclk), .cmd(cmd));
	initial forever #4 pclk = ~pclk;
	// Cut a hang short well beyond the 1500 or so cycles the run needs
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	function automatic logic [7:0] nom_ohm(input logic [2:0] c);
		case (c)
			3'h1: return 8'h3C;
			3'h2: return 8'h78;
			3'h3: return 8'h28;
			3'h4: return 8'h14;
			3'h5: return 8'h1E;
			default: return 8'h00;
		endcase
	endfunction
	function automatic logic [7:0] wr_ohm(input logic [1:0] c);
		return (c == 2'h1) ? 8'h3C : (c == 2'h2) ? 8'h78 : 8'h00;
	endfunction
	// ODT latency from CWL, AL code and CL: CWL + AL - 2
	function automatic int lat(input logic [1:0] al, input logic [2:0] cw, input logic [2:0] cl);
		int c;
		c = 4 + int'(cl);
		return 3 + int'(cw) + ((al == 2'h1) ? c - 1 : (al == 2'h2) ? c - 2 : 0);
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", n, x, g);
		end
	endtask
	// One APB transfer; holds everything until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Program MR0/MR1/MR2 and settle long enough that no old ODT sample is still in flight
	task automatic cfg(input logic [2:0] n, input logic [1:0] al, input logic [1:0] w,
		input logic [2:0] cw, input logic [2:0] cl);
		logic [31:0] m2;
		m2 = 32'(w) << 9 | 32'(cw) << 3;
		apb(1'b1, DTO_MR0_OFS, 32'(cl) << 4);
		apb(1'b1, DTO_MR1_OFS, 32'(n[2]) << 9 | 32'(n[1]) << 6 | 32'(al) << 3 | 32'(n[0]) << 2);
		apb(1'b1, DTO_MR2_OFS, m2);
		apb(1'b0, DTO_MR2_OFS, 32'h00000000);
		chk("mode readback", m2, q);
		odtl = lat(al, cw, cl);
		apb(1'b0, DTO_STAT_OFS, 32'h00000000);
		chk("latency", 32'(odtl), 32'(q[13:8]));
		chk("dynamic enable", 32'(w != 2'h0), 32'(q[4]));
		repeat (40) @(posedge pclk);
	endtask
	task automatic step(input int n, input logic [10:0] x);
		repeat (n) @(posedge pclk);
		#1;
		chk("termination", 32'(x), 32'({term.state, term.ohms, term.undef}));
	endtask
	// ODT pulse of window plus two samples, checked around each latency edge
	task automatic burst(input logic w, input logic b, input logic [10:0] n, input logic [10:0] m);
		int wl;
		wl = (w && !b) ? 6 : 4;
		fork
			u_model.pulse(wl + 2, w, b);
			begin
				@(posedge pclk);
				step(odtl + 1, 11'h000);
				step(1, m | 11'(m[10:9] == DTO_TERM_WR));
				step(wl - 1, m);
				step(1, n);
				step(1, n);
				step(1, 11'h000);
			end
		join
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 16; a += 4) begin
			apb(1'b0, 8'(a), 32'h00000000);
			chk("reset value", 32'h00000000, q);
		end
		apb(1'b1, DTO_CTRL_OFS, 32'hFFFFFFE7);
		apb(1'b0, DTO_CTRL_OFS, 32'h00000000);
		chk("control", 32'h00000007, q);
		apb(1'b1, DTO_STAT_OFS, 32'h00000000);
		chk("status write error", 32'h00000000, 32'(e));
		apb(1'b0, 8'h14, 32'h00000000);
		chk("unmapped error", 32'h00000001, 32'(e));
		chk("unmapped data", 32'h00000000, q);
		$display("test registers done");
		for (int c = 0; c < 6; c++) begin
			cfg(3'(c), 2'h0, 2'h0, 3'h0, 3'h0);
			chk("sync mode", 32'(c != 0), 32'(term.sync_mode));
			nv = (c == 0) ? 11'h000 : {DTO_TERM_NOM, nom_ohm(3'(c)), 1'b0};
			burst(1'b0, 1'b0, nv, nv);
		end
		$display("test nominal done");
		// Write termination stays clear here, as the DLL is turned off in some rows
		foreach (stab[i]) begin
			apb(1'b1, DTO_MR0_OFS, 32'(stab[i][5]) << 12);
			apb(1'b1, DTO_CTRL_OFS, 32'(stab[i][4:0]));
			#1;
			chk("sync mode", 32'(stab[i][7]), 32'(term.sync_mode));
		end
		// DLL not locked: the pin acts after one edge, with no latency
		odtl = 0;
		nv = {DTO_TERM_NOM, nom_ohm(3'h5), 1'b0};
		burst(1'b0, 1'b0, nv, nv);
		apb(1'b1, DTO_MR0_OFS, 32'h00000000);
		apb(1'b1, DTO_CTRL_OFS, 32'h00000007);
		$display("test sync mode done");
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			if (i < 2) r[6:2] = 5'h00; // Shortest latency with both burst lengths
			if (i < 2) r[8:7] = 2'(i + 1); // Both write strengths in the corner cases
			wc = (r[8:7] == 2'h3) ? 2'h0 : r[8:7]; // Reserved code never programmed
			nc = 3'h1 + 3'(r[1:0] % 3);
			b4 = (i < 2) ? i[0] : r[9];
			cfg(nc, r[3:2], wc, r[6:4], r[12:10]);
			nv = {DTO_TERM_NOM, nom_ohm(nc), 1'b0};
			mv = (wc != 2'h0) ? {DTO_TERM_WR, wr_ohm(wc), 1'b0} : nv;
			burst(1'b1, b4, nv, mv);
		end
		$display("test writes done");
		results();
	end
endmodule
